// >>> core/mrsc_map.vh
`ifndef MRSC_MAP_VH
`define MRSC_MAP_VH
// register byte addresses on the avalon slave
`define MRSC_ADDR_THRESH 4'h0
`define MRSC_ADDR_FLAGS 4'h4
`define MRSC_ADDR_WDOG 4'h8
`define MRSC_ADDR_STATUS 4'hC
// threshold select codes
`define MRSC_THR_2V10 8'h55
`define MRSC_THR_2V55 8'h33
`define MRSC_THR_2V35 8'h99
`define MRSC_THR_3V15 8'hA9
`define MRSC_THR_RESET 8'h55
// watchdog enable field codes, bits 7..3 of watchdog control
`define MRSC_WDE_ON_A 5'h15
`define MRSC_WDE_ON_B 5'h0A
`define MRSC_WDOG_RESET 8'h53
// flag register fields
`define MRSC_FLAGS_RESET 8'h00
`define MRSC_BIT_KEEP 7
`define MRSC_BIT_UV_FLAG 2
`define MRSC_BIT_THR_FLAG 1
`define MRSC_BIT_WDE_FLAG 0
// clock source codes for the restart delay
`define MRSC_CLK_FAST_RC 2'h0
`define MRSC_CLK_FAST_XT 2'h1
`define MRSC_CLK_SLOW_XT 2'h2
`define MRSC_CLK_SLOW_RC 2'h3
// restart delays in system clocks
`define MRSC_WAKE_FAST_RC 8'h10
`define MRSC_WAKE_XT 8'h80
`define MRSC_WAKE_SLOW_RC 8'h02
// power-on hold time in microseconds (16.7 ms) and clock rate
`define MRSC_HOLD_US 16700
`define MRSC_CLK_MHZ 25
`define MRSC_HOLD_CYC (`MRSC_HOLD_US * `MRSC_CLK_MHZ)
// cycles of 40 ns the undervoltage level must persist (qualify time, default)
`define MRSC_QUAL_CYC 32'd25
// reset pulse length in system clocks
`define MRSC_PULSE_CYC 4'h4
`endif

// >>> core/mrsc_sync.v
`timescale 1ns/1ps
// two-flop level synchroniser
module mrsc_sync
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// level in and out
	input wire i_level,
	output reg o_level
);
	reg stage1;
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			stage1 <= 1'b0;
			o_level <= 1'b0;
		end
		else
		begin
			stage1 <= i_level;
			o_level <= stage1;
		end
	end
endmodule // mrsc_sync

// >>> core/mrsc_top.v
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "mrsc_map.vh"
module mrsc_top
#(
	parameter HOLD_CYC = `MRSC_HOLD_CYC
)
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// avalon-mm slave
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	output reg [31:0] o_readdata,
	output wire o_waitrequest,
	// monitors and mode
	input wire i_power_on,
	input wire i_undervoltage,
	input wire i_sub_clk,
	input wire i_wdt_timeout,
	input wire i_sleep_idle,
	input wire i_power_down,
	input wire [1:0] i_clk_source,
	// to the core
	output reg o_core_hold,
	output reg o_pc_clear,
	output reg o_sp_top,
	output reg o_ports_high,
	output reg o_irq_disable,
	output reg o_timers_off,
	output reg o_wdt_clear,
	output reg o_full_reset,
	output reg o_timeout_status_flag,
	output reg o_power_down_status_flag
);
	reg [7:0] threshold_select_code;
	reg [7:0] wdog_ctrl;
	reg idle_sysclk_keep;
	reg low_voltage_reset_flag;
	reg bad_threshold_code_flag;
	reg bad_watchdog_code_flag;
	reg [31:0] qual_cnt;
	reg [31:0] hold_cnt;
	reg [7:0] wake_cnt;
	reg [3:0] pulse_cnt;
	reg [1:0] sub_hist;
	reg [1:0] thr_age;
	reg [1:0] wde_age;
	reg thr_req;
	reg wde_req;
	reg bad_thr_sub;
	reg bad_wde_sub;
	reg wdt_prev;
	reg done;
	reg [7:0] next_wake;
	reg read_ready;
	reg thr_ok;
	reg wde_ok;
	wire thr_req_s;
	wire wde_req_s;
	wire sub_rise;
	wire thr_bad;
	wire wde_bad;
	wire uv_reset_event;
	wire wdt_event;
	wire wdt_sleep_event;
	wire wdt_norm_event;
	wire full_event;
	wire wr_thr;
	wire wr_flags;
	wire wr_wdog;

	// reads take one wait state so the registered data stands when waitrequest drops
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			read_ready <= 1'b0;
		else
			read_ready <= i_read && !read_ready;
	end
	assign o_waitrequest = i_read && !read_ready;
	assign wr_thr = i_write && (i_address == `MRSC_ADDR_THRESH);
	assign wr_flags = i_write && (i_address == `MRSC_ADDR_FLAGS);
	assign wr_wdog = i_write && (i_address == `MRSC_ADDR_WDOG);

	// only the four listed codes are legal thresholds; anything else is taken as noise
	always @*
	begin
		case (threshold_select_code)
			`MRSC_THR_2V10: thr_ok = 1'b1;
			`MRSC_THR_2V55: thr_ok = 1'b1;
			`MRSC_THR_2V35: thr_ok = 1'b1;
			`MRSC_THR_3V15: thr_ok = 1'b1;
			default: thr_ok = 1'b0;
		endcase
	end
	assign thr_bad = !thr_ok;

	always @*
	begin
		case (wdog_ctrl[7:3])
			`MRSC_WDE_ON_A: wde_ok = 1'b1;
			`MRSC_WDE_ON_B: wde_ok = 1'b1;
			default: wde_ok = 1'b0;
		endcase
	end
	assign wde_bad = !wde_ok;

	// sub clock is sampled as a level; edges drive the 2-3 cycle ageing
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			sub_hist <= 2'h0;
		else
			sub_hist <= {sub_hist[0], i_sub_clk};
	end
	assign sub_rise = sub_hist[0] && !sub_hist[1];

	// checks sampled on sub-clock edges, request on the third sub edge after the code goes bad
	always @(posedge i_clk)
	begin
		if (!i_rst_n || o_full_reset)
		begin
			thr_age <= 2'h0;
			wde_age <= 2'h0;
			thr_req <= 1'b0;
			wde_req <= 1'b0;
			bad_thr_sub <= 1'b0;
			bad_wde_sub <= 1'b0;
		end
		else if (sub_rise)
		begin
			bad_thr_sub <= thr_bad;
			bad_wde_sub <= wde_bad;
			thr_age <= bad_thr_sub ? ((thr_age == 2'h2) ? thr_age : thr_age + 2'h1) : 2'h0;
			wde_age <= bad_wde_sub ? ((wde_age == 2'h2) ? wde_age : wde_age + 2'h1) : 2'h0;
			thr_req <= bad_thr_sub && (thr_age >= 2'h1);
			wde_req <= bad_wde_sub && (wde_age >= 2'h1);
		end
	end

	// requests cross through a two-flop synchroniser before acting
	mrsc_sync u_sync_thr
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_level(thr_req),
		.o_level(thr_req_s)
	);
	mrsc_sync u_sync_wde
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_level(wde_req),
		.o_level(wde_req_s)
	);

	// undervoltage qualification; disabled in power-down
	always @(posedge i_clk)
	begin
		if (!i_rst_n || i_power_down || !i_undervoltage)
			qual_cnt <= 32'd0;
		else if (qual_cnt <= `MRSC_QUAL_CYC)
			qual_cnt <= qual_cnt + 32'd1;
	end
	assign uv_reset_event = (qual_cnt == `MRSC_QUAL_CYC) && i_undervoltage && !i_power_down;

	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			wdt_prev <= 1'b0;
		else
			wdt_prev <= i_wdt_timeout;
	end
	assign wdt_event = i_wdt_timeout && !wdt_prev;
	assign wdt_sleep_event = wdt_event && i_sleep_idle;
	assign wdt_norm_event = wdt_event && !i_sleep_idle;
	assign full_event = uv_reset_event || wdt_norm_event || thr_req_s || wde_req_s;

	// registers and sticky flags; set wins over a software clear
	always @(posedge i_clk)
	begin
		if (!i_rst_n || i_power_on)
		begin
			threshold_select_code <= `MRSC_THR_RESET;
			wdog_ctrl <= `MRSC_WDOG_RESET;
			idle_sysclk_keep <= 1'b0;
			low_voltage_reset_flag <= 1'b0;
			bad_threshold_code_flag <= 1'b0;
			bad_watchdog_code_flag <= 1'b0;
			o_timeout_status_flag <= 1'b0;
			o_power_down_status_flag <= 1'b0;
		end
		else
		begin
			// a genuine low-voltage reset leaves the code as written
			if (thr_req_s)
				threshold_select_code <= `MRSC_THR_RESET;
			else if (wr_thr)
				threshold_select_code <= i_writedata[7:0];
			if (full_event)
				wdog_ctrl <= `MRSC_WDOG_RESET;
			else if (wr_wdog)
				wdog_ctrl <= i_writedata[7:0];
			if (wr_flags)
				idle_sysclk_keep <= i_writedata[`MRSC_BIT_KEEP];
			if (uv_reset_event)
				low_voltage_reset_flag <= 1'b1;
			else if (wr_flags && !i_writedata[`MRSC_BIT_UV_FLAG])
				low_voltage_reset_flag <= 1'b0;
			if (thr_req_s)
				bad_threshold_code_flag <= 1'b1;
			else if (wr_flags && !i_writedata[`MRSC_BIT_THR_FLAG])
				bad_threshold_code_flag <= 1'b0;
			if (wde_req_s)
				bad_watchdog_code_flag <= 1'b1;
			else if (wr_flags && !i_writedata[`MRSC_BIT_WDE_FLAG])
				bad_watchdog_code_flag <= 1'b0;
			if (wdt_event)
				o_timeout_status_flag <= 1'b1;
			if (wdt_sleep_event)
				o_power_down_status_flag <= 1'b1;
		end
	end

	// restart delay by clock source
	always @*
	begin
		case (i_clk_source)
			`MRSC_CLK_FAST_RC: next_wake = `MRSC_WAKE_FAST_RC;
			`MRSC_CLK_FAST_XT: next_wake = `MRSC_WAKE_XT;
			`MRSC_CLK_SLOW_XT: next_wake = `MRSC_WAKE_XT;
			default: next_wake = `MRSC_WAKE_SLOW_RC;
		endcase
	end

	// reset pulse and hold timing
	always @(posedge i_clk)
	begin
		if (!i_rst_n || i_power_on)
		begin
			pulse_cnt <= `MRSC_PULSE_CYC;
			hold_cnt <= 32'd0;
			wake_cnt <= 8'h00;
			done <= 1'b0;
			o_full_reset <= 1'b1;
			o_ports_high <= 1'b1;
			o_irq_disable <= 1'b1;
			o_timers_off <= 1'b1;
			o_wdt_clear <= 1'b1;
			o_sp_top <= 1'b1;
			o_pc_clear <= 1'b1;
			o_core_hold <= 1'b1;
		end
		else if (full_event)
		begin
			pulse_cnt <= `MRSC_PULSE_CYC;
			hold_cnt <= 32'd0;
			// a pending sleep restart must not replay once the full hold ends
			wake_cnt <= 8'h00;
			done <= 1'b0;
			o_full_reset <= 1'b1;
			o_ports_high <= 1'b1;
			o_irq_disable <= 1'b1;
			o_timers_off <= 1'b1;
			o_wdt_clear <= 1'b1;
			o_sp_top <= 1'b1;
			o_pc_clear <= 1'b1;
			o_core_hold <= 1'b1;
		end
		else if (wdt_sleep_event && done)
		begin
			wake_cnt <= next_wake;
			o_pc_clear <= 1'b1;
			o_sp_top <= 1'b1;
			o_core_hold <= 1'b1;
		end
		else if (!done)
		begin
			if (pulse_cnt != 4'h0)
				pulse_cnt <= pulse_cnt - 4'h1;
			else
			begin
				o_full_reset <= 1'b0;
				o_ports_high <= 1'b0;
				o_irq_disable <= 1'b0;
				o_timers_off <= 1'b0;
				o_wdt_clear <= 1'b0;
				o_sp_top <= 1'b0;
				o_pc_clear <= 1'b0;
			end
			if (hold_cnt >= HOLD_CYC - 1)
			begin
				done <= 1'b1;
				o_core_hold <= 1'b0;
			end
			else
				hold_cnt <= hold_cnt + 32'd1;
		end
		else if (wake_cnt != 8'h00)
		begin
			o_pc_clear <= 1'b0;
			o_sp_top <= 1'b0;
			wake_cnt <= wake_cnt - 8'h01;
			if (wake_cnt == 8'h01)
				o_core_hold <= 1'b0;
		end
	end

	// read data, registered; unmapped reads return zero
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_readdata <= 32'h00000000;
		else if (i_read && !read_ready)
		begin
			case (i_address)
				`MRSC_ADDR_THRESH: o_readdata <= {24'h000000, threshold_select_code};
				`MRSC_ADDR_FLAGS: o_readdata <= {24'h000000, idle_sysclk_keep, 4'h0, low_voltage_reset_flag,
					bad_threshold_code_flag, bad_watchdog_code_flag};
				`MRSC_ADDR_WDOG: o_readdata <= {24'h000000, wdog_ctrl};
				`MRSC_ADDR_STATUS: o_readdata <= {30'h00000000, o_power_down_status_flag, o_timeout_status_flag};
				default: o_readdata <= 32'h00000000;
			endcase
		end
	end
endmodule // mrsc_top

// >>> tb/mrsc_far_model.sv
`timescale 1ns/1ps
// supply monitor and sub oscillator seen by the block
module mrsc_far_model
(
	// clock
	input wire i_clk,
	// undervoltage request from the bench
	input wire i_uv_go,
	input wire [7:0] i_uv_len,
	// to the block
	output reg o_sub_clk = 1'b0,
	output reg o_undervoltage = 1'b0
);
	reg [3:0] div = 4'h0;
	reg [7:0] left = 8'h0;
	always @(posedge i_clk)
	begin
		div <= div + 4'h1;
		// sixteen system clocks a period: slow enough to be sampled as data
		o_sub_clk <= div[3];
		if (i_uv_go)
			left <= i_uv_len;
		else if (left != 8'h0)
			left <= left - 8'h1;
		o_undervoltage <= (left != 8'h0);
	end
endmodule // mrsc_far_model

// >>> tb/mrsc_top_props.sv
`timescale 1ns/1ps
`include "mrsc_map.vh"
module mrsc_top_chk
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// inputs watched
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_power_on,
	input wire i_wdt_timeout,
	input wire i_sleep_idle,
	// outputs watched
	input wire [31:0] o_readdata,
	input wire o_core_hold,
	input wire o_pc_clear,
	input wire o_sp_top,
	input wire o_ports_high,
	input wire o_irq_disable,
	input wire o_timers_off,
	input wire o_wdt_clear,
	input wire o_full_reset,
	input wire o_timeout_status_flag,
	input wire o_power_down_status_flag
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// sleep time-outs are only honoured once the hold is over
	sequence s_wn;
		$rose(i_wdt_timeout) && !i_sleep_idle && !o_core_hold;
	endsequence
	sequence s_ws;
		$rose(i_wdt_timeout) && i_sleep_idle && !o_core_hold;
	endsequence
	pc_por_a: assert property (i_power_on |=> o_pc_clear)
		else $error("pc clear missing after power-on");
	ports_por_a: assert property (i_power_on |=> o_ports_high)
		else $error("ports not high after power-on");
	por_side_a: assert property (i_power_on |=> o_irq_disable && o_timers_off && o_sp_top && o_wdt_clear)
		else $error("power-on strobes missing");
	por_flags_a: assert property ($rose(i_rst_n) || i_power_on |=> !o_timeout_status_flag && !o_power_down_status_flag)
		else $error("status flags not cleared by power-on");
	hold_full_a: assert property (o_full_reset |-> o_core_hold)
		else $error("full reset without hold");
	hold_len_a: assert property ($fell(o_full_reset) |-> o_core_hold [*8])
		else $error("hold ended too early");
	ro_bits_a: assert property (i_read && i_address == `MRSC_ADDR_FLAGS |=> o_readdata[6:3] == 4'h0)
		else $error("unused flag bits not zero");
	wdt_full_a: assert property (s_wn |-> ##[1:4] o_full_reset)
		else $error("no full reset on time-out");
	wdt_to_a: assert property (s_wn |-> ##[1:8] o_timeout_status_flag)
		else $error("time-out flag not set");
	sleep_pc_a: assert property (s_ws |-> ##[1:4] (o_pc_clear && o_sp_top))
		else $error("sleep time-out without pc and stack strobe");
	sleep_keep_a: assert property (s_ws |-> !o_full_reset [*6])
		else $error("sleep time-out made a full reset");
	sleep_flag_a: assert property (s_ws |-> ##[1:8] (o_timeout_status_flag && o_power_down_status_flag))
		else $error("sleep time-out flags not both set");
	cover property (s_wn);
	cover property (s_ws);
	cover property ($rose(o_full_reset));
endmodule // mrsc_top_chk
bind mrsc_top mrsc_top_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
	.i_power_on(i_power_on), .i_wdt_timeout(i_wdt_timeout), .i_sleep_idle(i_sleep_idle), .o_readdata(o_readdata),
	.o_core_hold(o_core_hold), .o_pc_clear(o_pc_clear), .o_sp_top(o_sp_top), .o_ports_high(o_ports_high),
	.o_irq_disable(o_irq_disable), .o_timers_off(o_timers_off), .o_wdt_clear(o_wdt_clear),
	.o_full_reset(o_full_reset), .o_timeout_status_flag(o_timeout_status_flag),
	.o_power_down_status_flag(o_power_down_status_flag));

// >>> tb/mrsc_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module mrsc_top_tb_top;
	reg i_clk = 1'b0;
	reg i_rst_n = 1'b0;
	reg [3:0] i_address = 4'h0;
	reg i_read = 1'b0;
	reg i_write = 1'b0;
	reg [31:0] i_writedata = 32'h0;
	reg i_power_on = 1'b0;
	reg i_wdt_timeout = 1'b0;
	reg i_sleep_idle = 1'b0;
	reg i_power_down = 1'b0;
	reg [1:0] i_clk_source = 2'h0;
	reg uv_go = 1'b0;
	reg [7:0] uv_len = 8'h0;
	wire i_sub_clk;
	wire i_undervoltage;
	wire [31:0] o_readdata;
	wire o_waitrequest;
	wire o_core_hold;
	wire o_full_reset;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	reg [7:0] thr [4] = '{8'h55, 8'h33, 8'h99, 8'hA9};
	int dly [4] = '{16, 128, 128, 2};
	mrsc_far_model u_far (.i_clk(i_clk), .i_uv_go(uv_go), .i_uv_len(uv_len), .o_sub_clk(i_sub_clk),
		.o_undervoltage(i_undervoltage));
	// short hold keeps every full reset to some fifty cycles
	mrsc_top #(.HOLD_CYC(50)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_power_on(i_power_on), .i_undervoltage(i_undervoltage), .i_sub_clk(i_sub_clk),
		.i_wdt_timeout(i_wdt_timeout), .i_sleep_idle(i_sleep_idle), .i_power_down(i_power_down),
		.i_clk_source(i_clk_source), .o_core_hold(o_core_hold), .o_pc_clear(), .o_sp_top(), .o_ports_high(),
		.o_irq_disable(), .o_timers_off(), .o_wdt_clear(), .o_full_reset(o_full_reset),
		.o_timeout_status_flag(), .o_power_down_status_flag());
	initial
	begin
		forever #20 i_clk = ~i_clk;
	end
	task results;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			results();
		end
	end
	task wr(input [3:0] a, input [7:0] v);
		@(posedge i_clk);
		i_address <= a;
		i_writedata <= {24'h0, v};
		i_write <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		i_write <= 1'b0;
	endtask
	// read data is taken at the edge where waitrequest is seen low, then the read is released
	task chk(input [3:0] a, input [7:0] e);
		@(posedge i_clk);
		i_address <= a;
		i_read <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		`CHK(o_readdata, {24'h0, e})
		i_read <= 1'b0;
	endtask
	task wfr(input int lim, output int k);
		k = 0;
		while (o_full_reset === 1'b0 && k < lim)
		begin
			@(posedge i_clk);
			k++;
		end
	endtask
	task whd(output int k);
		k = 0;
		while (o_core_hold !== 1'b0 && k < 1000)
		begin
			@(posedge i_clk);
			k++;
		end
	endtask
	task uvp(input [7:0] len);
		@(posedge i_clk);
		uv_len <= len;
		uv_go <= 1'b1;
		@(posedge i_clk);
		uv_go <= 1'b0;
	endtask
	task wdp;
		@(posedge i_clk);
		i_wdt_timeout <= 1'b1;
		@(posedge i_clk);
		i_wdt_timeout <= 1'b0;
	endtask
	initial
	begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		whd(n);
		`CHK(n > 40 && n < 60, 1'b1)
		chk(4'h0, 8'h55);
		chk(4'h4, 8'h00);
		chk(4'hC, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h0, thr[i]);
			chk(4'h0, thr[i]);
			wfr(80, n);
			`CHK(n, 80)
		end
		wr(4'h0, 8'h12);
		wfr(100, n);
		`CHK(n >= 16 && n <= 60, 1'b1)
		whd(n);
		chk(4'h0, 8'h55);
		chk(4'h4, 8'h02);
		wr(4'h4, 8'h7D);
		chk(4'h4, 8'h00);
		uvp(8'd20);
		wfr(60, n);
		`CHK(n, 60)
		i_power_down <= 1'b1;
		uvp(8'd40);
		wfr(100, n);
		`CHK(n, 100)
		i_power_down <= 1'b0;
		wr(4'h0, 8'h33);
		uvp(8'd40);
		wfr(100, n);
		`CHK(n < 100, 1'b1)
		whd(n);
		chk(4'h0, 8'h33);
		chk(4'hC, 8'h00);
		wr(4'h4, 8'h04);
		chk(4'h4, 8'h04);
		wr(4'h4, 8'h00);
		chk(4'h4, 8'h00);
		wr(4'h4, 8'h80);
		chk(4'h4, 8'h80);
		wr(4'h4, 8'h00);
		wr(4'h8, 8'hAB);
		wfr(80, n);
		`CHK(n, 80)
		wr(4'h8, 8'h00);
		wfr(100, n);
		`CHK(n >= 16 && n <= 60, 1'b1)
		whd(n);
		chk(4'h8, 8'h53);
		chk(4'h4, 8'h01);
		wdp();
		wfr(10, n);
		`CHK(n < 10, 1'b1)
		whd(n);
		chk(4'hC, 8'h01);
		wr(4'h0, 8'hA9);
		i_sleep_idle <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			i_clk_source <= i[1:0];
			wdp();
			n = 0;
			while (o_core_hold !== 1'b1 && n < 10)
			begin
				@(posedge i_clk);
				n++;
			end
			whd(n);
			`CHK(n >= dly[i] - 2 && n <= dly[i] + 1, 1'b1)
			chk(4'hC, 8'h03);
		end
		chk(4'h0, 8'hA9);
		i_sleep_idle <= 1'b0;
		@(posedge i_clk);
		i_power_on <= 1'b1;
		@(posedge i_clk);
		i_power_on <= 1'b0;
		// the hold is launched at this edge; count from the first edge that shows it
		@(posedge i_clk);
		whd(n);
		`CHK(n > 40 && n < 60, 1'b1)
		chk(4'hC, 8'h00);
		chk(4'h0, 8'h55);
		results();
	end
endmodule // mrsc_top_tb_top
